// *** tcw_regs.vh ***
// Constants for the table-walk configuration block: offsets, fields, resets
// Assumes a 32-bit AHB-Lite slave port and a word-wide descriptor fetch port
// Summary of operation
// - Initial shift bits excluded from every index
// - Initial shift accepts zero to fifteen
// - Page size fixes untranslated low bits
// - Eight page sizes, 256 to 32K bytes
// - Function-code level indexed by three bits
// - Next level indexed just below shifted bits
// - Level A width gives its index bits
// - First zero width ends tree; last is page
// - Each index sits directly below previous one
// - Up to five levels, four optional
// - Root limit bounds the first index
// - Table, page, invalid, indirect in both formats
// - Root only table or early-termination page
// - Early-termination page stops search, maps contiguously
// - Intermediate levels: table, early page, invalid
// - Lowest level: page, indirect, invalid; follow indirect
// - Short is one word, long two words
// - Type field is low two bits of first word
// - Invalid descriptor ends search with bus error
// - Unused descriptor fields are ignored
`ifndef TCW_REGS_VH
`define TCW_REGS_VH
// Register byte offsets
`define TCW_OFF_CTRL 8'h00
`define TCW_OFF_ROOT_HI 8'h04
`define TCW_OFF_ROOT_LO 8'h08
`define TCW_OFF_WALK_FC 8'h0c
`define TCW_OFF_WALK_LA 8'h10
`define TCW_OFF_STATUS 8'h14
`define TCW_OFF_RESULT 8'h18
`define TCW_OFF_DERIVED 8'h1c
// Control word fields
`define TCW_FCL_BIT 24
`define TCW_PS_LSB 20
`define TCW_IS_LSB 16
`define TCW_TIA_LSB 12
`define TCW_TIB_LSB 8
`define TCW_TIC_LSB 4
`define TCW_TID_LSB 0
`define TCW_PS_MIN 4'h8
`define TCW_CTRL_RST 32'h00000000
// Root and long descriptor upper word fields
`define TCW_LU_BIT 31
`define TCW_LIM_LSB 16
`define TCW_ROOT_HI_RST 32'h7fff0002
`define TCW_ROOT_LO_RST 32'h00000000
// Descriptor type codes
`define TCW_DT_INVALID 2'h0
`define TCW_DT_PAGE 2'h1
`define TCW_DT_SHORT 2'h2
`define TCW_DT_LONG 2'h3
// Status bits
`define TCW_ST_BUSY 0
`define TCW_ST_DONE 1
`define TCW_ST_BERR 2
`define TCW_ST_LIMIT 3
`define TCW_ST_CFG 4
`define TCW_ST_EARLY 5
`define TCW_ST_INDIR 6
`endif

// *** tcw_walk.v ***
// Table-walk configuration decoder and descriptor walker with AHB-Lite slave
// Assumes descriptor memory answers mem_ack on core_clk, one word per ack
//
// Decided for this implementation: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
module tcw_walk
(
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Descriptor memory port
  output reg mem_req_q,
  output reg [31:0] mem_addr_q,
  input wire mem_ack,
  input wire [31:0] mem_rdata,
  // Walk result
  output reg walk_done_q,
  output reg walk_busy_q
);
`include "tcw_regs.vh"

  localparam S_IDLE = 3'h0;
  localparam S_ISSUE = 3'h1;
  localparam S_WAIT0 = 3'h2;
  localparam S_WAIT1 = 3'h3;
  localparam S_DECODE = 3'h4;

  // Mask of the n lowest bits
  function [31:0] low_mask;
    input [5:0] n;
    begin
      if (n >= 6'd32)
        low_mask = 32'hffffffff;
      else
        low_mask = (32'h00000001 << n) - 32'h00000001;
    end
  endfunction

  reg [31:0] ctrl_q;
  reg [31:0] root_hi_q;
  reg [31:0] root_lo_q;
  reg [2:0] fc_q;
  reg [31:0] la_q;
  reg [31:0] result_q;
  reg [6:0] st_q;
  reg [2:0] state_q;
  reg [2:0] lvl_q;
  reg long_q;
  reg indir_q;
  reg has_lim_q;
  reg lu_q;
  reg [14:0] lim_q;
  reg [31:0] base_q;
  reg [31:0] word0_q;
  reg [31:0] word1_q;
  reg ph_q;
  reg ph_wr_q;
  reg [7:0] ph_addr_q;

  // Field extraction
  wire [3:0] is_w = ctrl_q[`TCW_IS_LSB+3:`TCW_IS_LSB];
  wire [3:0] ps_w = ctrl_q[`TCW_PS_LSB+3:`TCW_PS_LSB];
  wire fcl_w = ctrl_q[`TCW_FCL_BIT];
  wire [3:0] tia_w = ctrl_q[`TCW_TIA_LSB+3:`TCW_TIA_LSB];
  wire [3:0] tib_w = ctrl_q[`TCW_TIB_LSB+3:`TCW_TIB_LSB];
  wire [3:0] tic_w = ctrl_q[`TCW_TIC_LSB+3:`TCW_TIC_LSB];
  wire [3:0] tid_w = ctrl_q[`TCW_TID_LSB+3:`TCW_TID_LSB];

  // Widths after the first zero among B, C and D count as zero
  wire [3:0] wb = tib_w;
  wire [3:0] wc = (tib_w == 4'h0) ? 4'h0 : tic_w;
  wire [3:0] wd = (wc == 4'h0) ? 4'h0 : tid_w;

  // Last address level: 1=A .. 4=D, page tables live there
  wire [2:0] last_lvl = (wd != 4'h0) ? 3'd4 : (wc != 4'h0) ? 3'd3 :
    (wb != 4'h0) ? 3'd2 : 3'd1;

  // Cumulative consumed bits above each level's low edge
  wire [5:0] end_a = {2'b00, is_w} + {2'b00, tia_w};
  wire [5:0] end_b = end_a + {2'b00, wb};
  wire [5:0] end_c = end_b + {2'b00, wc};
  wire [5:0] end_d = end_c + {2'b00, wd};

  // Page size 256..32K selects 8..15 offset bits
  wire ps_ok = (ps_w >= `TCW_PS_MIN);
  wire [5:0] sum_all = end_d + {2'b00, ps_w};

  // Configuration error check
  wire cfg_bad = !ps_ok || (sum_all != 6'd32) || (tia_w == 4'h0) ||
    ((tib_w == 4'h0) && (tia_w < 4'h2));

  // Current level width and end position
  reg [3:0] cur_w;
  reg [5:0] cur_end;
  always @*
  begin
    cur_w = 4'h0;
    cur_end = 6'd0;
    case (lvl_q)
      3'd1:
      begin
        cur_w = tia_w;
        cur_end = end_a;
      end
      3'd2:
      begin
        cur_w = wb;
        cur_end = end_b;
      end
      3'd3:
      begin
        cur_w = wc;
        cur_end = end_c;
      end
      3'd4:
      begin
        cur_w = wd;
        cur_end = end_d;
      end
      default:
      begin
        cur_w = 4'h0;
        cur_end = {2'b00, is_w};
      end
    endcase
  end

  // Index for the current level
  wire [5:0] low_bit = 6'd32 - cur_end;
  wire [31:0] la_shift = la_q >> low_bit;
  wire [31:0] idx_w = (lvl_q == 3'd0) ? {29'h0, fc_q} :
    (la_shift & low_mask({2'b00, cur_w}));
  wire [14:0] idx15 = idx_w[14:0];
  wire lim_bad = has_lim_q && (lu_q ? (idx15 < lim_q) : (idx15 > lim_q));
  wire [31:0] idx_off = long_q ? (idx_w << 3) : (idx_w << 2);

  // Decode of fetched descriptor
  wire [1:0] dt_w = word0_q[1:0];
  wire [31:0] dbase = long_q ? word1_q : word0_q;
  wire leaf_w = (lvl_q == last_lvl);
  wire [31:0] la_below = la_q & low_mask(low_bit);
  // Only used at the start edge, where the address register loads this very bus word
  wire [31:0] la_root = hwdata & low_mask(6'd32 - {2'b00, is_w});
  wire [31:0] la_page = la_q & low_mask({2'b00, ps_w});

  // AHB write strobes for the current data phase
  wire bus_take = hsel && htrans[1] && hready;
  wire wr_go = ph_q && ph_wr_q;
  wire wr_la = wr_go && (ph_addr_q == `TCW_OFF_WALK_LA);
  wire wr_st = wr_go && (ph_addr_q == `TCW_OFF_STATUS);
  wire start = wr_la && (state_q == S_IDLE);

  // Walk completion and event strobes
  reg fin;
  reg ev_berr;
  reg ev_lim;
  reg ev_cfg;
  reg ev_early;
  reg ev_ind;

  // Readback value for the latched address
  reg [31:0] rd_val;
  always @*
  begin
    rd_val = 32'h00000000;
    case (ph_addr_q)
      `TCW_OFF_CTRL: rd_val = ctrl_q;
      `TCW_OFF_ROOT_HI: rd_val = root_hi_q;
      `TCW_OFF_ROOT_LO: rd_val = root_lo_q;
      `TCW_OFF_WALK_FC: rd_val = {29'h0, fc_q};
      `TCW_OFF_WALK_LA: rd_val = la_q;
      `TCW_OFF_STATUS: rd_val = {25'h0, st_q[6:1], walk_busy_q};
      `TCW_OFF_RESULT: rd_val = result_q;
      `TCW_OFF_DERIVED: rd_val = {20'h0, ps_ok, last_lvl, fcl_w, cfg_bad, end_d};
      default: rd_val = 32'h00000000;
    endcase
  end

  // Bus slave: one wait cycle per transfer, always OKAY
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ph_q <= 1'b0;
      ph_wr_q <= 1'b0;
      ph_addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end
    else if (ph_q)
    begin
      ph_q <= 1'b0;
      hreadyout <= 1'b1;
      if (!ph_wr_q)
        hrdata <= rd_val;
    end
    else if (bus_take)
    begin
      ph_q <= 1'b1;
      ph_wr_q <= hwrite;
      ph_addr_q <= {haddr[7:2], 2'b00};
      hreadyout <= 1'b0;
    end
  end

  // Software-written settings; walk inputs frozen while busy
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= `TCW_CTRL_RST;
      root_hi_q <= `TCW_ROOT_HI_RST;
      root_lo_q <= `TCW_ROOT_LO_RST;
      fc_q <= 3'h0;
      la_q <= 32'h00000000;
    end
    else if (wr_go && (state_q == S_IDLE))
    begin
      case (ph_addr_q)
        `TCW_OFF_CTRL: ctrl_q <= hwdata;
        `TCW_OFF_ROOT_HI: root_hi_q <= hwdata;
        `TCW_OFF_ROOT_LO: root_lo_q <= hwdata;
        `TCW_OFF_WALK_FC: fc_q <= hwdata[2:0];
        `TCW_OFF_WALK_LA: la_q <= hwdata;
        default: fc_q <= fc_q;
      endcase
    end
  end

  // Walk sequencer
  always @*
  begin
    fin = 1'b0;
    ev_berr = 1'b0;
    ev_lim = 1'b0;
    ev_cfg = 1'b0;
    ev_early = 1'b0;
    ev_ind = 1'b0;
    if (start && cfg_bad)
    begin
      fin = 1'b1;
      ev_cfg = 1'b1;
    end
    else if (start && (root_hi_q[1] == 1'b0) && (root_hi_q[0] == 1'b0))
    begin
      fin = 1'b1;
      ev_cfg = 1'b1;
    end
    else if (start && (root_hi_q[1:0] == `TCW_DT_PAGE))
    begin
      fin = 1'b1;
      ev_early = 1'b1;
    end
    else if ((state_q == S_ISSUE) && lim_bad)
    begin
      fin = 1'b1;
      ev_lim = 1'b1;
    end
    else if (state_q == S_DECODE)
    begin
      if (dt_w == `TCW_DT_INVALID)
      begin
        fin = 1'b1;
        ev_berr = 1'b1;
      end
      else if (indir_q && (dt_w != `TCW_DT_PAGE))
      begin
        fin = 1'b1;
        ev_berr = 1'b1;
      end
      else if (dt_w == `TCW_DT_PAGE)
      begin
        fin = 1'b1;
        ev_early = !leaf_w && !indir_q;
      end
      else if (leaf_w && !indir_q)
        ev_ind = 1'b1;
    end
  end

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= S_IDLE;
      lvl_q <= 3'd0;
      long_q <= 1'b0;
      indir_q <= 1'b0;
      has_lim_q <= 1'b0;
      lu_q <= 1'b0;
      lim_q <= 15'h0000;
      base_q <= 32'h00000000;
      word0_q <= 32'h00000000;
      word1_q <= 32'h00000000;
      result_q <= 32'h00000000;
      mem_req_q <= 1'b0;
      mem_addr_q <= 32'h00000000;
      walk_busy_q <= 1'b0;
      walk_done_q <= 1'b0;
    end
    else
    begin
      walk_done_q <= fin;
      if (fin)
      begin
        state_q <= S_IDLE;
        walk_busy_q <= 1'b0;
        mem_req_q <= 1'b0;
      end
      case (state_q)
        S_IDLE:
        begin
          if (start && !fin)
          begin
            // Root is a table pointer; its limit bounds the first index
            state_q <= S_ISSUE;
            walk_busy_q <= 1'b1;
            lvl_q <= fcl_w ? 3'd0 : 3'd1;
            long_q <= root_hi_q[0];
            indir_q <= 1'b0;
            has_lim_q <= 1'b1;
            lu_q <= root_hi_q[`TCW_LU_BIT];
            lim_q <= root_hi_q[`TCW_LIM_LSB+14:`TCW_LIM_LSB];
            base_q <= {root_lo_q[31:4], 4'h0};
          end
          else if (start)
            result_q <= {root_lo_q[31:8], 8'h00} + la_root;
        end
        S_ISSUE:
        begin
          if (!lim_bad)
          begin
            mem_req_q <= 1'b1;
            mem_addr_q <= base_q + idx_off;
            state_q <= S_WAIT0;
          end
        end
        S_WAIT0:
        begin
          if (mem_ack)
          begin
            word0_q <= mem_rdata;
            // Long descriptor needs its second word
            if (long_q)
              mem_addr_q <= mem_addr_q + 32'h00000004;
            else
            begin
              mem_req_q <= 1'b0;
              state_q <= S_DECODE;
            end
            if (long_q)
              state_q <= S_WAIT1;
          end
        end
        S_WAIT1:
        begin
          if (mem_ack)
          begin
            word1_q <= mem_rdata;
            mem_req_q <= 1'b0;
            state_q <= S_DECODE;
          end
        end
        S_DECODE:
        begin
          // Unused fields of descriptors are never looked at
          if (fin && (dt_w == `TCW_DT_PAGE))
          begin
            if (ev_early)
              result_q <= {dbase[31:8], 8'h00} + la_below;
            else
              result_q <= {dbase[31:8], 8'h00} | la_page;
          end
          else if (!fin && leaf_w && !indir_q)
          begin
            // Indirect: fetch the page descriptor it points to
            indir_q <= 1'b1;
            long_q <= dt_w[0];
            mem_req_q <= 1'b1;
            mem_addr_q <= {dbase[31:2], 2'b00};
            state_q <= S_WAIT0;
          end
          else if (!fin)
          begin
            // Next table; short tables carry no limit
            lvl_q <= lvl_q + 3'd1;
            long_q <= dt_w[0];
            has_lim_q <= long_q;
            lu_q <= word0_q[`TCW_LU_BIT];
            lim_q <= word0_q[`TCW_LIM_LSB+14:`TCW_LIM_LSB];
            base_q <= {dbase[31:4], 4'h0};
            state_q <= S_ISSUE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Sticky status; a new event beats a same-cycle write-one clear
  wire [6:0] st_set = {ev_ind, ev_early, ev_cfg, ev_lim, ev_berr, fin, 1'b0};
  wire [6:0] st_clr = (wr_st ? hwdata[6:0] : 7'h00) | (start ? 7'h7e : 7'h00);
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= 7'h00;
    else
      st_q <= (st_q & ~st_clr) | st_set;
  end

endmodule // tcw_walk

// *** tcw_walk_chk.sv ***
// Port checker for the table-walk block
// Assumes it is bound to tcw_walk, one clock domain
`timescale 1ns/100ps
module tcw_walk_chk
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Fetch port and walk state
  input wire logic mem_req_q,
  input wire logic [31:0] mem_addr_q,
  input wire logic mem_ack,
  input wire logic walk_done_q,
  input wire logic walk_busy_q
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // Accepted address phase
  wire acc = hsel & htrans[1] & hready;
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_wait_once: assert property (acc |=> !hreadyout ##1 hreadyout)
    else $error("wait state not exactly one cycle");
  a_wait_cause: assert property (!hreadyout |-> $past(acc))
    else $error("wait state without a transfer");
  a_fetch_hold: assert property (mem_req_q && !mem_ack |=> mem_req_q && $stable(mem_addr_q))
    else $error("fetch dropped or moved before ack");
  a_fetch_word: assert property (mem_req_q |-> mem_addr_q[1:0] == 2'b00)
    else $error("fetch address not word aligned");
  a_done_pulse: assert property (walk_done_q |=> !walk_done_q)
    else $error("done longer than one cycle");
  a_fetch_busy: assert property (mem_req_q |-> walk_busy_q)
    else $error("fetch outside a walk");
  a_walk_start: assert property (acc && hwrite && haddr[7:0] == 8'h10 && !walk_busy_q
    |-> ##2 (walk_busy_q || walk_done_q))
    else $error("address write did not start a walk");
  // Main scenarios seen
  c_write: cover property (acc && hwrite);
  c_two_word: cover property (mem_ack ##1 mem_req_q);
  c_done: cover property (walk_done_q);
endmodule // tcw_walk_chk

// *** tcw_mem_model.sv ***
// Descriptor memory on the far side of the walker's fetch port
// Assumes the bench fills mem and sets lat before each walk
`timescale 1ns/100ps
module tcw_mem_model
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Fetch port
  input wire logic mem_req_q,
  input wire logic [31:0] mem_addr_q,
  output logic mem_ack = 1'b0,
  output logic [31:0] mem_rdata = 32'h0
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] log_q [$];
  int lat = 0;
  int cnt = 0;
  // One word per ack after lat wait cycles; idle data toggles so stale reads show
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_ack <= 1'b0;
      cnt <= 0;
    end
    else if (mem_req_q && !mem_ack && cnt >= lat)
    begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_addr_q];
      log_q.push_back(mem_addr_q);
      cnt <= 0;
    end
    else
    begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      cnt <= mem_req_q ? cnt + 1 : 0;
    end
  end
endmodule // tcw_mem_model

// *** tcw_walk_tb.sv ***
// Self-checking bench: walks through the register bus against a memory model
// Assumes tcw_walk, tcw_walk_chk and tcw_mem_model are compiled before it
`timescale 1ns/100ps
`include "tcw_regs.vh"
module tcw_walk_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire [31:0] hrdata, mem_addr_q, mem_rdata;
  wire hreadyout, hresp, mem_req_q, mem_ack, walk_done_q, walk_busy_q;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] st, res, d;
  // IS 4, 256 B pages, widths 4/8/8: every field in range, sum of 32
  localparam logic [31:0] CW = 32'h00844880;
  localparam logic [31:0] LA = 32'hf1234567;
  // Single slave: its ready is the bus ready
  tcw_walk DUT
  (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mem_req_q(mem_req_q), .mem_addr_q(mem_addr_q),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .walk_done_q(walk_done_q),
    .walk_busy_q(walk_busy_q)
  );
  tcw_mem_model mdl
  (
    .core_clk(core_clk), .rst_n(rst_n), .mem_req_q(mem_req_q), .mem_addr_q(mem_addr_q),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata)
  );
  // Clock generator
  initial
  begin
    forever #2 core_clk = ~core_clk;
  end
  // Hang guard
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors = errors + 1;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Single AHB-Lite word transfer; read data lands in d
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  task automatic cmp_log(input logic [31:0] e [$]);
    chk(mdl.log_q.size(), e.size());
    foreach (e[i]) chk(mdl.log_q[i], e[i]);
  endtask
  // Set up, start a walk, try a refused write when slow, then fetch the outcome
  task automatic walk(input logic [31:0] ctl, rh, fc, input int lat);
    int n;
    ahb(1'b1, `TCW_OFF_CTRL, ctl);
    ahb(1'b1, `TCW_OFF_ROOT_HI, rh);
    ahb(1'b1, `TCW_OFF_ROOT_LO, 32'h1000);
    ahb(1'b1, `TCW_OFF_WALK_FC, fc);
    mdl.lat = lat;
    mdl.log_q.delete();
    ahb(1'b1, `TCW_OFF_WALK_LA, LA);
    if (lat > 3)
    begin
      ahb(1'b1, `TCW_OFF_CTRL, 32'h0);
      ahb(1'b0, `TCW_OFF_CTRL, 32'h0);
      chk(d, ctl);
    end
    n = 0;
    while (walk_done_q !== 1'b1 && n < 500)
    begin
      @(posedge core_clk);
      n++;
    end
    chk(n, n % 500);
    ahb(1'b0, `TCW_OFF_STATUS, 32'h0);
    st = d;
    ahb(1'b0, `TCW_OFF_RESULT, 32'h0);
    res = d;
    $display("walk test done, latency %0d", lat);
  endtask
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    mdl.mem[32'h1004] = 32'h00002002;
    mdl.mem[32'h208c] = 32'h00003002;
    mdl.mem[32'h3114] = 32'h00abcd01;
    mdl.mem[32'h4000] = 32'h00abcd01;
    mdl.mem[32'h1008] = 32'h7fff0002;
    mdl.mem[32'h100c] = 32'h00002000;
    mdl.mem[32'h1014] = 32'h00005002;
    mdl.mem[32'h5004] = 32'h00900001;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    ahb(1'b0, `TCW_OFF_ROOT_HI, 32'h0);
    chk(d, `TCW_ROOT_HI_RST);
    ahb(1'b0, 8'h20, 32'h0);
    chk(d, 32'h0);
    $display("reset test done");
    ahb(1'b1, `TCW_OFF_CTRL, CW);
    ahb(1'b0, `TCW_OFF_DERIVED, 32'h0);
    chk(d & 32'h8ff, 32'h818);
    ahb(1'b1, `TCW_OFF_CTRL, 32'h00400000);
    ahb(1'b0, `TCW_OFF_DERIVED, 32'h0);
    chk(d & 32'h840, 32'h040);
    $display("decode test done");
    walk(CW, 32'h00010002, 32'h0, 6);
    chk(st & 32'h7e, 32'h02);
    chk(res, 32'h00abcd67);
    cmp_log('{32'h1004, 32'h208c, 32'h3114});
    mdl.mem[32'h208c] = 32'h00700001;
    walk(CW, 32'h7fff0002, 32'h0, 0);
    chk(st & 32'h7e, 32'h22);
    chk(res, 32'h00704567);
    cmp_log('{32'h1004, 32'h208c});
    mdl.mem[32'h208c] = 32'h00000000;
    walk(CW, 32'h7fff0002, 32'h0, 2);
    chk(st & 32'h7e, 32'h06);
    mdl.mem[32'h208c] = 32'h00003002;
    mdl.mem[32'h3114] = 32'h00004002;
    walk(CW, 32'h7fff0002, 32'h0, 6);
    chk(st & 32'h7e, 32'h42);
    chk(res, 32'h00abcd67);
    cmp_log('{32'h1004, 32'h208c, 32'h3114, 32'h4000});
    mdl.mem[32'h3114] = 32'h00abcd01;
    walk(CW, 32'h7fff0003, 32'h0, 0);
    chk(res, 32'h00abcd67);
    cmp_log('{32'h1008, 32'h100c, 32'h208c, 32'h3114});
    walk(32'h01844880, 32'h7fff0002, 32'h5, 1);
    chk(res, 32'h00b34567);
    cmp_log('{32'h1014, 32'h5004});
    walk(CW, 32'h00000002, 32'h0, 0);
    chk(st & 32'h0a, 32'h0a);
    chk(mdl.log_q.size(), 0);
    walk(CW, 32'h80020002, 32'h0, 0);
    chk(st & 32'h0a, 32'h0a);
    chk(mdl.log_q.size(), 0);
    walk(CW, 32'h7fff0001, 32'h0, 0);
    chk(st & 32'h7e, 32'h22);
    chk(res, 32'h01235567);
    chk(mdl.log_q.size(), 0);
    walk(CW, 32'h7fff0000, 32'h0, 0);
    chk(st & 32'h12, 32'h12);
    results();
  end
endmodule // tcw_walk_tb
bind tcw_walk tcw_walk_chk u_chk
(
  .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .mem_req_q(mem_req_q), .mem_addr_q(mem_addr_q), .mem_ack(mem_ack),
  .walk_done_q(walk_done_q), .walk_busy_q(walk_busy_q)
);
